//--- sim/periodic_timer_tb.sv
/*
 * Self-checking bench for periodic_timer over APB, one task per scenario.
 * Assumes tick held high, except in the timer_mode freeze check, so one count per clock while running.
 */
`timescale 1ns/1ps
module periodic_timer_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tick = 1'b1;
    logic fire = 1'b0;
    logic trig;
    logic timer_out;
    logic timer_out_en;
    logic [31:0] rd;
    logic err;
    int rises;
    int mismatches = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    periodic_timer u_dut (.clk(clk), .nrst(nrst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tick(tick), .external_trigger_pin(trig),
        .timer_out(timer_out), .timer_out_en(timer_out_en));

    trigger_pin_model u_pin (.clk(clk), .fire(fire), .rises(rises), .trig(trig),
        .pin(timer_out));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            mismatches++;
            results();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rdchk

    task automatic highs(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge clk);
            if (timer_out === 1'b1) h++;
        end
    endtask : highs

    // Mode and action only change with the timer stopped
    task automatic arm(input logic [31:0] c, input logic [31:0] d, input logic [31:0] p);
        wr(periodic_timer_pkg::OFS_RUN, 32'h0000_0000);
        wr(periodic_timer_pkg::OFS_STATUS, 32'h0000_0003);
        wr(periodic_timer_pkg::OFS_CTL, c);
        wr(periodic_timer_pkg::OFS_DUTY, d);
        wr(periodic_timer_pkg::OFS_PERIOD, p);
        wr(periodic_timer_pkg::OFS_RUN, 32'h0000_0001);
    endtask : arm

    task automatic reset_regs();
        rdchk(periodic_timer_pkg::OFS_CTL, 32'h0000_0000);
        rdchk(periodic_timer_pkg::OFS_DUTY, 32'h0000_0000);
        rdchk(periodic_timer_pkg::OFS_STATUS, 32'h0000_0000);
        wr(periodic_timer_pkg::OFS_CTL, 32'h0000_00ff);
        rdchk(periodic_timer_pkg::OFS_CTL, 32'h0000_00fd);
        wr(periodic_timer_pkg::OFS_COUNT, 32'h0000_0055);
        rdchk(periodic_timer_pkg::OFS_COUNT, 32'h0000_0000);
        rdchk(12'h018, 32'h0000_0000);
        check(err, 1'b1);
    endtask : reset_regs

    // Pin actions after one duty match: low, high, none, none from low
    task automatic compare_actions();
        logic [31:0] c [4] = '{32'h18, 32'h20, 32'h08, 32'h00};
        logic e [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
        for (int k = 0; k < 4; k++) begin
            arm(c[k], 32'd20, 32'd30);
            repeat (2) @(posedge clk);
            check(timer_out, c[k][3]);
            repeat (40) @(posedge clk);
            check(timer_out, e[k]);
        end
        rdchk(periodic_timer_pkg::OFS_STATUS, 32'h0000_0003);
        apb(1'b0, periodic_timer_pkg::OFS_COUNT, 32'h0000_0000);
        check(rd < 32'd30, 1'b1);
    endtask : compare_actions

    task automatic compare_toggle_clear_duty();
        int r0;
        arm(32'h31, 32'd4, 32'd1);
        repeat (20) @(posedge clk);
        r0 = rises;
        repeat (80) @(posedge clk);
        check(rises - r0, 32'd10);
        rdchk(periodic_timer_pkg::OFS_STATUS, 32'h0000_0001);
        apb(1'b0, periodic_timer_pkg::OFS_COUNT, 32'h0000_0000);
        check(rd < 32'd4, 1'b1);
    endtask : compare_toggle_clear_duty

    task automatic timer_mode();
        arm(32'h40, 32'd3, 32'd5);
        repeat (4) @(posedge clk);
        check(timer_out_en, 1'b0);
        arm(32'hc0, 32'd3, 32'd5);
        repeat (20) @(posedge clk);
        check(timer_out_en, 1'b0);
        check(timer_out, 1'b0);
        rdchk(periodic_timer_pkg::OFS_STATUS, 32'h0000_0003);
        arm(32'hc0, 32'd0, 32'd0);
        repeat (1100) @(posedge clk);
        apb(1'b0, periodic_timer_pkg::OFS_STATUS, 32'h0000_0000);
        check(rd[0], 1'b0);
        wr(periodic_timer_pkg::OFS_RUN, 32'h0000_0000);
        apb(1'b0, periodic_timer_pkg::OFS_COUNT, 32'h0000_0000);
        rdchk(periodic_timer_pkg::OFS_COUNT, rd);
        wr(periodic_timer_pkg::OFS_RUN, 32'h0000_0001);
        apb(1'b0, periodic_timer_pkg::OFS_COUNT, 32'h0000_0000);
        check(rd < 32'd8, 1'b1);
        // No tick, no count: the value must freeze while run stays high
        @(posedge clk);
        tick <= 1'b0;
        apb(1'b0, periodic_timer_pkg::OFS_COUNT, 32'h0000_0000);
        repeat (20) @(posedge clk);
        rdchk(periodic_timer_pkg::OFS_COUNT, rd);
        tick <= 1'b1;
    endtask : timer_mode

    // Control, duty, period, window and expected high cycles
    task automatic pwm_table();
        logic [31:0] c [7] = '{32'ha8, 32'hac, 32'ha9, 32'h88, 32'h98, 32'ha8, 32'ha8};
        logic [31:0] d [7] = '{2, 2, 10, 2, 2, 512, 1};
        logic [31:0] p [7] = '{8, 8, 8, 8, 8, 0, 1023};
        int n [7] = '{80, 80, 80, 80, 80, 2048, 2046};
        int e [7] = '{20, 60, 80, 0, 80, 1024, 2};
        // Duty above period never matches, so only the period flag rises
        logic [31:0] f [7] = '{3, 3, 2, 3, 3, 3, 3};
        int h;
        for (int k = 0; k < 7; k++) begin
            arm(c[k], d[k], p[k]);
            repeat (16) @(posedge clk);
            highs(n[k], h);
            check(h, e[k]);
            rdchk(periodic_timer_pkg::OFS_STATUS, f[k]);
        end
    endtask : pwm_table

    task automatic single_pulse();
        int h;
        int r0;
        arm(32'hb8, 32'd5, 32'd2);
        highs(40, h);
        check(h >= 5 && h <= 7, 1'b1);
        rdchk(periodic_timer_pkg::OFS_RUN, 32'h0000_0000);
        rdchk(periodic_timer_pkg::OFS_STATUS, 32'h0000_0001);
        wr(periodic_timer_pkg::OFS_STATUS, 32'h0000_0003);
        r0 = rises;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        highs(40, h);
        check(rises - r0, 32'd1);
        rdchk(periodic_timer_pkg::OFS_STATUS, 32'h0000_0001);
    endtask : single_pulse

    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        check(timer_out_en, 1'b1);
        reset_regs();
        compare_actions();
        compare_toggle_clear_duty();
        timer_mode();
        pwm_table();
        single_pulse();
        results();
    end
endmodule : periodic_timer_tb

//--- sim/trigger_pin_model.sv
/*
 * Far-side pin model: external trigger source and timer output observer.
 * Assumes the bench asks for a trigger with a one-cycle fire request.
 */
`timescale 1ns/1ps
module trigger_pin_model (
    // Clock
    input wire logic clk,
    // Bench side
    input wire logic fire,
    output int rises,
    // Timer pins
    output logic trig,
    input wire logic pin
);
    int hold = 0;
    logic last = 1'b0;

    initial trig = 1'b0;
    initial rises = 0;

    // Trigger held a few cycles so a slow sampler still sees the edge
    always @(posedge clk) begin
        last <= pin;
        if (pin === 1'b1 && last === 1'b0) rises <= rises + 1;
        if (fire === 1'b1) hold <= 3;
        else if (hold > 0) hold <= hold - 1;
        trig <= (fire === 1'b1) || (hold > 1);
    end
endmodule : trigger_pin_model

//--- verilog/counter_if.sv
/*
 * Carrier between the timer control logic and its counter unit.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface counter_if;
    logic tick;
    logic run;
    logic restart;
    logic clear_sel;
    periodic_timer_pkg::mode_t mode;
    logic [9:0] duty;
    logic [9:0] period;
    logic [9:0] count;
    logic duty_hit;
    logic period_hit;

    modport ctrl (
        output tick, run, restart, clear_sel, mode, duty, period,
        input count, duty_hit, period_hit
    );
    modport unit (
        input tick, run, restart, clear_sel, mode, duty, period,
        output count, duty_hit, period_hit
    );
endinterface : counter_if

//--- verilog/match_counter.sv
/*
 * 10-bit counter with duty and period comparators.
 * Assumes restart is a one-cycle pulse on the run bit's rising edge.
 */
`timescale 1ns/1ps
module match_counter (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control side
    counter_if.unit cif
);
    typedef struct packed {
        logic [9:0] count;
    } state_t;

    state_t s;
    state_t next_s;
    logic step;
    logic cmp_like;
    logic clear;

    always_comb begin
        next_s = s;
        step = cif.run && cif.tick && !cif.restart;
        cmp_like = (cif.mode == periodic_timer_pkg::MODE_COMPARE) ||
                   (cif.mode == periodic_timer_pkg::MODE_TIMER);
        // Zero duty value never matches; a duty-cleared counter then overflows
        cif.duty_hit = step && (cif.duty != 10'h000) &&
                       (s.count == cif.duty - 10'h001);
        // Period zero compares against 3FF, which is the overflow
        cif.period_hit = step && (s.count == cif.period - 10'h001) &&
                         ((cif.mode == periodic_timer_pkg::MODE_PWM) ||
                          (cmp_like && !cif.clear_sel));
        clear = cif.period_hit || (cmp_like && cif.clear_sel && cif.duty_hit);
        if (cif.restart) begin
            next_s.count = 10'h000;
        end else if (step) begin
            next_s.count = clear ? 10'h000 : s.count + 10'h001;
        end
        cif.count = s.count;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    restart_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        cif.restart |=> (s.count == 10'h000)) else $error("counter not zeroed on restart");
    stop_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        !cif.run && !cif.restart |=> $stable(s.count)) else $error("stopped counter moved");
    duty_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cif.duty == 10'h000) |-> !cif.duty_hit) else $error("duty hit with zero duty");
    pulse_no_pf_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cif.mode == periodic_timer_pkg::MODE_PULSE) |-> !cif.period_hit)
        else $error("period hit in single pulse mode");

endmodule : match_counter

//--- verilog/periodic_timer.sv
/*
 * Periodic timer operating modes with an APB register slave.
 * Assumes tick is a one-cycle enable from clock-source logic and the
 * trigger pin is already synchronous to clk.
 */
`timescale 1ns/1ps
module periodic_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer clock enable
    input wire logic tick,
    // External pins
    input wire logic external_trigger_pin,
    output logic timer_out,
    output logic timer_out_en
);
    typedef struct packed {
        logic run_bit;
        logic run_prev;
        logic trig_prev;
        logic [7:0] ctl;
        logic [9:0] duty;
        logic [9:0] period;
        logic duty_match_flag;
        logic period_match_flag;
        logic pin_level;
        logic timer_out;
        logic timer_out_en;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    state_t s;
    state_t next_s;
    logic rst_meta;
    logic rst_n;
    periodic_timer_pkg::mode_t mode;
    logic run_rise;
    logic wr;
    logic active;
    logic level;
    logic [1:0] action;

    counter_if cif ();

    match_counter u_counter (
        .clk(clk),
        .rst_n(rst_n),
        .cif(cif)
    );

    // Reset release through two flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    always_comb begin
        mode = periodic_timer_pkg::decode_mode(s.ctl);
        action = s.ctl[periodic_timer_pkg::ACT_HI:periodic_timer_pkg::ACT_LO];
        run_rise = s.run_bit && !s.run_prev;
        cif.tick = tick;
        cif.run = s.run_bit;
        cif.restart = run_rise;
        cif.clear_sel = s.ctl[periodic_timer_pkg::CLR_SEL];
        cif.mode = mode;
        cif.duty = s.duty;
        cif.period = s.period;
    end

    always_comb begin
        next_s = s;
        wr = psel && penable && s.pready && pwrite;
        next_s.run_prev = s.run_bit;
        next_s.trig_prev = external_trigger_pin;

        // Trigger edge arms a single pulse
        if (mode == periodic_timer_pkg::MODE_PULSE && external_trigger_pin && !s.trig_prev) begin
            next_s.run_bit = 1'b1;
        end
        if (mode == periodic_timer_pkg::MODE_PULSE && cif.duty_hit) begin
            next_s.run_bit = 1'b0;
        end

        // Register writes; a software write to run overrides the hardware
        if (wr) begin
            case (paddr)
                periodic_timer_pkg::OFS_RUN: begin
                    next_s.run_bit = pwdata[periodic_timer_pkg::RUN_BIT];
                end
                periodic_timer_pkg::OFS_CTL: begin
                    next_s.ctl = pwdata[7:0];
                    next_s.ctl[periodic_timer_pkg::RSVD] = 1'b0;
                end
                periodic_timer_pkg::OFS_DUTY: begin
                    next_s.duty = pwdata[9:0];
                end
                periodic_timer_pkg::OFS_PERIOD: begin
                    next_s.period = pwdata[9:0];
                end
                periodic_timer_pkg::OFS_STATUS: begin
                    next_s.duty_match_flag = s.duty_match_flag &&
                                             !pwdata[periodic_timer_pkg::DUTY_FLAG];
                    next_s.period_match_flag = s.period_match_flag &&
                                               !pwdata[periodic_timer_pkg::PERIOD_FLAG];
                end
                default: begin
                end
            endcase
        end

        // Set after clear so a same-cycle event is kept
        if (cif.duty_hit) begin
            next_s.duty_match_flag = 1'b1;
        end
        if (cif.period_hit) begin
            next_s.period_match_flag = 1'b1;
        end

        // Compare-mode pin: initial level on run rise, action on duty match
        if (run_rise) begin
            next_s.pin_level = s.ctl[periodic_timer_pkg::INIT_LVL];
        end else if (cif.duty_hit) begin
            case (action)
                periodic_timer_pkg::ACT_LOW: next_s.pin_level = 1'b0;
                periodic_timer_pkg::ACT_HIGH: next_s.pin_level = 1'b1;
                periodic_timer_pkg::ACT_TOGGLE: next_s.pin_level = !s.pin_level;
                default: next_s.pin_level = s.pin_level;
            endcase
        end

        // PWM and pulse waveform; counter keeps running when forced
        case (action)
            periodic_timer_pkg::ACT_NONE: active = 1'b0;
            periodic_timer_pkg::ACT_LOW: active = 1'b1;
            // Count stays below a nonzero period, so duty >= period is always active
            periodic_timer_pkg::ACT_HIGH: active = cif.count < s.duty;
            default: active = s.run_bit;
        endcase
        if (mode == periodic_timer_pkg::MODE_COMPARE) begin
            level = next_s.pin_level;
        end else begin
            level = active ? s.ctl[periodic_timer_pkg::INIT_LVL] :
                             !s.ctl[periodic_timer_pkg::INIT_LVL];
        end
        next_s.timer_out_en = mode != periodic_timer_pkg::MODE_TIMER;
        next_s.timer_out = next_s.timer_out_en &&
                           (level ^ s.ctl[periodic_timer_pkg::INVERT]);

        // APB: data and error prepared in setup, answered in first access cycle
        next_s.pready = psel && !penable;
        next_s.pslverr = 1'b0;
        next_s.prdata = periodic_timer_pkg::RDATA_RESET;
        if (psel && !penable) begin
            case (paddr)
                periodic_timer_pkg::OFS_RUN: next_s.prdata = {31'h0, s.run_bit};
                periodic_timer_pkg::OFS_CTL: next_s.prdata = {24'h00_0000, s.ctl};
                periodic_timer_pkg::OFS_DUTY: next_s.prdata = {22'h0, s.duty};
                periodic_timer_pkg::OFS_PERIOD: next_s.prdata = {22'h0, s.period};
                periodic_timer_pkg::OFS_COUNT: next_s.prdata = {22'h0, cif.count};
                periodic_timer_pkg::OFS_STATUS: begin
                    next_s.prdata = {30'h0, s.period_match_flag, s.duty_match_flag};
                end
                default: next_s.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign timer_out = s.timer_out;
    assign timer_out_en = s.timer_out_en;

    timer_undriven_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.ctl[7:6] == periodic_timer_pkg::MODE_CODE_TMR) |=> !s.timer_out_en)
        else $error("pin driven in timer mode");
    cmp_no_pf_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_COMPARE && s.ctl[periodic_timer_pkg::CLR_SEL])
        |-> !cif.period_hit) else $error("period hit with duty clear");
    pin_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cif.duty_hit && !run_rise && action == periodic_timer_pkg::ACT_LOW)
        |=> !s.pin_level) else $error("drive-low action missed");
    pin_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!cif.duty_hit && !run_rise) |=> $stable(s.pin_level))
        else $error("pin moved without duty match");
    run_init_a: assert property (@(posedge clk) disable iff (!rst_n)
        run_rise |=> (s.pin_level == $past(s.ctl[periodic_timer_pkg::INIT_LVL])))
        else $error("initial level not loaded");
    pulse_end_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PULSE && cif.duty_hit && !wr)
        |=> !s.run_bit ##1 (!s.timer_out_en || (s.timer_out ==
            (s.ctl[periodic_timer_pkg::INVERT] ^ !s.ctl[periodic_timer_pkg::INIT_LVL]))))
            else $error("pulse did not end");
    flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cif.duty_hit |=> s.duty_match_flag) else $error("duty flag not set");
    flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.period_match_flag && !(wr && paddr == periodic_timer_pkg::OFS_STATUS))
        |=> s.period_match_flag) else $error("period flag dropped");
    pwm_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PWM && action == periodic_timer_pkg::ACT_HIGH &&
         s.period != 10'h000 && s.duty >= s.period && !wr)
        |=> (s.timer_out == ($past(s.ctl[periodic_timer_pkg::INIT_LVL]) ^
                             $past(s.ctl[periodic_timer_pkg::INVERT]))))
        else $error("PWM not fully active");

    // Pin action per code on a duty match
    pin_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cif.duty_hit && !run_rise && action == periodic_timer_pkg::ACT_HIGH) |=> s.pin_level)
        else $error("drive-high action missed");
    pin_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cif.duty_hit && !run_rise && action == periodic_timer_pkg::ACT_TOGGLE)
        |=> (s.pin_level != $past(s.pin_level))) else $error("toggle action missed");
    pin_none_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cif.duty_hit && !run_rise && action == periodic_timer_pkg::ACT_NONE)
        |=> $stable(s.pin_level)) else $error("pin moved with no action");
    cmp_out_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_COMPARE)
        |=> (s.timer_out == (s.pin_level ^ $past(s.ctl[periodic_timer_pkg::INVERT]))))
        else $error("compare output level wrong");
    timer_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_TIMER) |=> !s.timer_out)
        else $error("output active in timer mode");

    // Forced levels must not stop the waveform logic behind them
    pwm_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PWM && action == periodic_timer_pkg::ACT_NONE)
        |=> (s.timer_out == (!$past(s.ctl[periodic_timer_pkg::INIT_LVL]) ^
                             $past(s.ctl[periodic_timer_pkg::INVERT]))))
        else $error("forced inactive level wrong");
    pwm_forced_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PWM && action == periodic_timer_pkg::ACT_LOW)
        |=> (s.timer_out == ($past(s.ctl[periodic_timer_pkg::INIT_LVL]) ^
                             $past(s.ctl[periodic_timer_pkg::INVERT]))))
        else $error("forced active level wrong");
    pulse_level_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PULSE) |=> (s.timer_out ==
            (($past(s.run_bit) ~^ $past(s.ctl[periodic_timer_pkg::INIT_LVL])) ^
             $past(s.ctl[periodic_timer_pkg::INVERT])))) else $error("pulse level wrong");
    trig_start_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PULSE && external_trigger_pin && !s.trig_prev &&
         !cif.duty_hit && !wr) |=> s.run_bit) else $error("trigger did not start pulse");
    run_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode != periodic_timer_pkg::MODE_PULSE && !wr) |=> $stable(s.run_bit))
        else $error("run bit moved outside pulse mode");
    duty_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        (s.duty_match_flag && !(wr && paddr == periodic_timer_pkg::OFS_STATUS))
        |=> s.duty_match_flag) else $error("duty flag dropped");
    pf_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        cif.period_hit |=> s.period_match_flag) else $error("period flag not set");
    duty_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_COMPARE && s.ctl[periodic_timer_pkg::CLR_SEL] &&
         cif.duty_hit) |=> (cif.count == 10'h000)) else $error("duty match did not clear");

    // Period zero still has to end the frame at the top count
    wrap_period_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PWM && s.period == 10'h000 && s.run_bit && tick &&
         !run_rise && cif.count == 10'h3ff) |-> cif.period_hit)
        else $error("no frame end at top count");
    pulse_no_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (mode == periodic_timer_pkg::MODE_PULSE && !run_rise && cif.count != 10'h3ff)
        |=> (cif.count >= $past(cif.count))) else $error("counter cleared mid pulse");

endmodule : periodic_timer

//--- verilog/periodic_timer_pkg.sv
/*
 * Shared constants, mode type and mode decoder for the periodic timer.
 * Assumes a 32-bit APB slave with 12-bit byte addresses.
 */
package periodic_timer_pkg;

    localparam int CNT_W = 10;
    localparam int ADDR_W = 12;

    // Register byte offsets
    localparam logic [11:0] OFS_RUN = 12'h000;
    localparam logic [11:0] OFS_CTL = 12'h004;
    localparam logic [11:0] OFS_DUTY = 12'h008;
    localparam logic [11:0] OFS_PERIOD = 12'h00c;
    localparam logic [11:0] OFS_COUNT = 12'h010;
    localparam logic [11:0] OFS_STATUS = 12'h014;

    // Field positions in timer_control_one
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int ACT_HI = 5;
    localparam int ACT_LO = 4;
    localparam int INIT_LVL = 3;
    localparam int INVERT = 2;
    localparam int RSVD = 1;
    localparam int CLR_SEL = 0;

    // Field positions in the run and status registers
    localparam int RUN_BIT = 0;
    localparam int DUTY_FLAG = 0;
    localparam int PERIOD_FLAG = 1;

    // Mode field codes
    localparam logic [1:0] MODE_CODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CODE_PWM = 2'h2;
    localparam logic [1:0] MODE_CODE_TMR = 2'h3;

    // Pin action codes
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;

    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [9:0] CMP_RESET = 10'h000;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_COMPARE,
        MODE_PWM,
        MODE_PULSE,
        MODE_TIMER
    } mode_t;

    // Undefined code 01 is treated as timer/counter: pin left undriven
    function automatic mode_t decode_mode(input logic [7:0] ctl);
        mode_t m;
        case (ctl[MODE_HI:MODE_LO])
            MODE_CODE_CMP: m = MODE_COMPARE;
            MODE_CODE_PWM: m = (ctl[ACT_HI:ACT_LO] == ACT_TOGGLE) ? MODE_PULSE : MODE_PWM;
            default: m = MODE_TIMER;
        endcase
        return m;
    endfunction : decode_mode

endpackage : periodic_timer_pkg
